// [uet_pkg.sv]
// uet_pkg: register map, field positions and carrier types of the
// endpoint 0 toggle / flush / count / speed block.
// assumes a 32-bit classic Wishbone bus with byte addresses.
package uet_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL_HIGH = 10'h103;
    localparam logic [9:0] IDX_RX_COUNT  = 10'h108;
    localparam logic [9:0] IDX_SPEED     = 10'h10A;
    localparam logic [9:0] IDX_MODE      = 10'h110;
    localparam logic [9:0] IDX_READY     = 10'h111;
    localparam logic [9:0] IDX_IRQ_STAT  = 10'h112;
    localparam logic [9:0] IDX_IRQ_MASK  = 10'h113;
    // ep0_control_high fields
    localparam int BIT_FLUSH  = 0;
    localparam int BIT_TOGGLE = 1;
    localparam int BIT_TWE    = 2;
    // ep0_target_speed field
    localparam int SPEED_LSB = 6;
    localparam logic [1:0] SPEED_FULL = 2'h2;
    localparam logic [1:0] SPEED_LOW  = 2'h3;
    // mode register: bit 0 selects host mode
    localparam int BIT_HOST = 0;
    // ready register: bit 0 transmit ready (W1S), bit 1 receive ready
    // (read, write 1 clears)
    localparam int BIT_TRANSMIT_PACKET_READY = 0;
    localparam int BIT_RECEIVE_PACKET_READY = 1;
    // interrupt status / mask layout
    localparam int IRQ_TX_DONE = 0;
    localparam int IRQ_RX_PKT  = 1;
    localparam int IRQ_W       = 2;
    // reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    // endpoint 0 fifo depth in bytes
    localparam int EP0_DEPTH = 64;

    // one Wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } uet_wb_req_type;

    // events from the endpoint 0 packet engine
    typedef struct packed {
        logic tx_done;      // packet sent
        logic rx_pkt;       // packet received completely
        logic rx_byte;      // one byte written into fifo
        logic fifo_pop;     // one byte read out of fifo
        logic toggle_flip;  // toggle advanced after a good transfer
        logic toggle_clear; // toggle reset, e.g. by a setup
    } uet_evt_type;
endpackage

// [uet_ep0_ctrl.sv]
// uet_ep0_ctrl: endpoint 0 data toggle, fifo flush, received byte count,
// target speed, ready flags and interrupt, behind a Wishbone slave.
// assumes the packet engine drives uet_evt_type pulses on ref_clk_i.
//
// Behaviour
// - host mode: writing one to bit 2 arms toggle write; clears after use
// - host mode: bit 1 of control high reads current data toggle
// - toggle bit write only takes effect while toggle write enable armed
// - writing one to bit 0 flushes packet, pointer and ready flags
// - count register bits 6:0 hold received bytes; bit 7 reads zero
// - received byte count follows fifo contents as they change
// - speed bits 7:6: 10 full, 11 low; 00, 01 reserved
// - software sets transmit ready; hardware clears after send, interrupts
// - hardware sets receive ready on packet reception and interrupts
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module uet_ep0_ctrl #(
    parameter int DEPTH = uet_pkg::EP0_DEPTH
) (
    input  wire logic                    ref_clk_i,   // 200 MHz clock
    input  wire logic                    resetn_i,    // async reset, low
    input  wire uet_pkg::uet_wb_req_type wb_req_i,    // bus request
    output logic [31:0]                  wb_dat_o,    // read data
    output logic                         wb_ack_o,    // bus answer
    input  wire uet_pkg::uet_evt_type    evt_i,       // engine events
    output logic                         host_mode_o, // host role select
    output logic                         toggle_o,    // data toggle
    output logic [1:0]                   speed_o,     // target speed
    output logic                         tx_ready_o,  // packet loaded
    output logic                         rx_ready_o,  // packet received
    output logic                         flush_o,     // fifo flush pulse
    output logic [6:0]                   count_o,     // bytes in fifo
    output logic                         irq_o        // interrupt level
);
    import uet_pkg::*;

    // refuse depths the 7-bit count cannot hold
    if (DEPTH < 1 || DEPTH > 127) begin : g_bad_depth
        $error("uet_ep0_ctrl: DEPTH must be 1..127");
    end

    localparam logic [6:0] DEPTH_C = 7'(DEPTH);

    // register index decode for a byte address
    function automatic logic hit(input logic [11:0] adr,
                                 input logic [9:0] idx);
        hit = (adr[11:2] == idx);
    endfunction

    logic             ack_r, ack_nxt;
    logic [31:0]      dat_r, dat_nxt;
    logic             host_r, host_nxt;
    logic             toggle_r, toggle_nxt;
    logic             twe_r, twe_nxt;
    logic [1:0]       speed_r, speed_nxt;
    logic             transmit_packet_ready_r, transmit_packet_ready_nxt;
    logic             receive_packet_ready_r, receive_packet_ready_nxt;
    logic             flush_r, flush_nxt;
    logic [6:0]       count_r, count_nxt;
    logic [IRQ_W-1:0] stat_r, stat_nxt;
    logic [IRQ_W-1:0] mask_r, mask_nxt;

    logic       req;
    logic       wr;
    logic       rd;
    logic [7:0] wbyte;
    logic       do_flush;
    logic [IRQ_W-1:0] evt_set;

    // request decode; an access completes at the edge where ack is high
    assign req   = wb_req_i.cyc & wb_req_i.stb;
    assign wr    = req & wb_req_i.we & ack_r & wb_req_i.sel[0];
    assign rd    = req & ~wb_req_i.we & ack_r;
    assign wbyte = wb_req_i.dat[7:0];
    assign do_flush = wr & hit(wb_req_i.adr, IDX_CTRL_HIGH)
                    & wbyte[BIT_FLUSH];

    // interrupt sources
    always_comb begin
        evt_set = '0;
        evt_set[IRQ_TX_DONE] = evt_i.tx_done & transmit_packet_ready_r;
        evt_set[IRQ_RX_PKT]  = evt_i.rx_pkt;
    end

    // bus slave: ack one cycle after request, read data captured then
    always_comb begin
        ack_nxt = req & ~ack_r;
        dat_nxt = dat_r;
        if (req && !ack_r) begin
            dat_nxt = RST_WORD;
            case (wb_req_i.adr[11:2])
                IDX_CTRL_HIGH: begin
                    if (host_r) begin
                        dat_nxt[BIT_TOGGLE] = toggle_r;
                        dat_nxt[BIT_TWE]    = twe_r;
                    end
                end
                IDX_RX_COUNT:  dat_nxt[6:0] = count_r;
                IDX_SPEED:     dat_nxt[SPEED_LSB +: 2] = speed_r;
                IDX_MODE:      dat_nxt[BIT_HOST] = host_r;
                IDX_READY: begin
                    dat_nxt[BIT_TRANSMIT_PACKET_READY] = transmit_packet_ready_r;
                    dat_nxt[BIT_RECEIVE_PACKET_READY] = receive_packet_ready_r;
                end
                IDX_IRQ_STAT:  dat_nxt[IRQ_W-1:0] = stat_r;
                IDX_IRQ_MASK:  dat_nxt[IRQ_W-1:0] = mask_r;
                default:       dat_nxt = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_r <= 1'b0;
            dat_r <= RST_WORD;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // configuration: host mode, target speed, interrupt mask
    always_comb begin
        host_nxt  = host_r;
        speed_nxt = speed_r;
        mask_nxt  = mask_r;
        if (wr && hit(wb_req_i.adr, IDX_MODE)) begin
            host_nxt = wbyte[BIT_HOST];
        end
        if (wr && hit(wb_req_i.adr, IDX_SPEED)) begin
            speed_nxt = wbyte[SPEED_LSB +: 2];
        end
        if (wr && hit(wb_req_i.adr, IDX_IRQ_MASK)) begin
            mask_nxt = wbyte[IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            host_r  <= 1'b0;
            speed_r <= RST_BYTE[1:0];
            mask_r  <= RST_BYTE[IRQ_W-1:0];
        end else begin
            host_r  <= host_nxt;
            speed_r <= speed_nxt;
            mask_r  <= mask_nxt;
        end
    end

    // data toggle with guarded software write
    always_comb begin
        toggle_nxt = toggle_r;
        twe_nxt    = twe_r;
        if (evt_i.toggle_clear) begin
            toggle_nxt = 1'b0;
        end else if (evt_i.toggle_flip) begin
            toggle_nxt = ~toggle_r;
        end
        if (wr && hit(wb_req_i.adr, IDX_CTRL_HIGH) && host_r) begin
            if (twe_r) begin
                toggle_nxt = wbyte[BIT_TOGGLE];
                twe_nxt    = 1'b0;
            end else if (wbyte[BIT_TWE]) begin
                twe_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            toggle_r <= 1'b0;
            twe_r    <= 1'b0;
        end else begin
            toggle_r <= toggle_nxt;
            twe_r    <= twe_nxt;
        end
    end

    // ready flags, flush pulse and received byte count
    always_comb begin
        transmit_packet_ready_nxt = transmit_packet_ready_r;
        receive_packet_ready_nxt = receive_packet_ready_r;
        count_nxt = count_r;
        flush_nxt = do_flush;
        if (evt_i.tx_done) begin
            transmit_packet_ready_nxt = 1'b0;
        end
        if (wr && hit(wb_req_i.adr, IDX_READY)) begin
            if (wbyte[BIT_TRANSMIT_PACKET_READY]) begin
                transmit_packet_ready_nxt = 1'b1;
            end
            if (wbyte[BIT_RECEIVE_PACKET_READY]) begin
                receive_packet_ready_nxt = 1'b0;
            end
        end
        if (evt_i.rx_pkt) begin
            receive_packet_ready_nxt = 1'b1;
        end
        if (evt_i.rx_byte && !evt_i.fifo_pop && count_r < DEPTH_C) begin
            count_nxt = count_r + 7'h01;
        end else if (evt_i.fifo_pop && !evt_i.rx_byte
                     && count_r != 7'h00) begin
            count_nxt = count_r - 7'h01;
        end
        if (do_flush) begin
            transmit_packet_ready_nxt = 1'b0;
            receive_packet_ready_nxt = 1'b0;
            count_nxt = 7'h00;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            transmit_packet_ready_r <= 1'b0;
            receive_packet_ready_r <= 1'b0;
            count_r <= RST_BYTE[6:0];
            flush_r <= 1'b0;
        end else begin
            transmit_packet_ready_r <= transmit_packet_ready_nxt;
            receive_packet_ready_r <= receive_packet_ready_nxt;
            count_r <= count_nxt;
            flush_r <= flush_nxt;
        end
    end

    // sticky status; a read clears only the bits it returned
    always_comb begin
        stat_nxt = stat_r;
        if (rd && hit(wb_req_i.adr, IDX_IRQ_STAT)) begin
            stat_nxt = stat_r & ~dat_r[IRQ_W-1:0];
        end
        stat_nxt = stat_nxt | evt_set;                           // set wins
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stat_r <= RST_BYTE[IRQ_W-1:0];
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // outputs
    assign wb_dat_o    = dat_r;
    assign wb_ack_o    = ack_r;
    assign host_mode_o = host_r;
    assign toggle_o    = toggle_r;
    assign speed_o     = speed_r;
    assign tx_ready_o  = transmit_packet_ready_r;
    assign rx_ready_o  = receive_packet_ready_r;
    assign flush_o     = flush_r;
    assign count_o     = count_r;
    assign irq_o       = |(stat_r & mask_r);
endmodule

// [uet_ep0_ctrl_properties.sv]
// checker for uet_ep0_ctrl: bus answer, flush, toggle, count, flags
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module uet_ep0_ctrl_properties #(
    parameter int DEPTH = 64
) (
    input wire logic                    ref_clk_i,  // clock
    input wire logic                    resetn_i,   // reset, low
    input wire uet_pkg::uet_wb_req_type wb_req_i,   // bus request
    input wire logic [31:0]             wb_dat_o,   // read data
    input wire logic                    wb_ack_o,   // bus answer
    input wire uet_pkg::uet_evt_type    evt_i,      // engine events
    input wire logic                    host_mode_o, // host role
    input wire logic                    toggle_o,   // data toggle
    input wire logic [1:0]              speed_o,    // target speed
    input wire logic                    tx_ready_o, // transmit ready
    input wire logic                    rx_ready_o, // receive ready
    input wire logic                    flush_o,    // flush pulse
    input wire logic [6:0]              count_o     // fifo bytes
);
    import uet_pkg::*;
    // decoded write at the ack edge and register hits
    wire wr   = wb_ack_o & wb_req_i.cyc & wb_req_i.stb & wb_req_i.we
              & wb_req_i.sel[0];
    wire is_c = wb_req_i.adr[11:2] == IDX_CTRL_HIGH;
    wire is_r = wb_req_i.adr[11:2] == IDX_READY;
    wire is_s = wb_req_i.adr[11:2] == IDX_SPEED;
    wire is_n = wb_req_i.adr[11:2] == IDX_RX_COUNT;
    wire fl   = wr & is_c & wb_req_i.dat[BIT_FLUSH];
    // causes that may move the toggle, and the written toggle value
    wire tg_evt   = evt_i.toggle_flip | evt_i.toggle_clear;
    wire tg_cause = tg_evt | (wr & is_c);
    wire sp_wr    = wr & is_s;
    wire wr_dt    = wb_req_i.dat[BIT_TOGGLE];
    logic armed_r, armed_nxt;
    // arm state of the guarded toggle write, rebuilt from the bus
    always_comb begin
        armed_nxt = armed_r;
        if (wr && is_c && host_mode_o) begin
            armed_nxt = !armed_r && wb_req_i.dat[BIT_TWE];
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            armed_r <= 1'b0;
        end else begin
            armed_r <= armed_nxt;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    chk_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb
        && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_flush_clear: assert property (fl |=> flush_o && !tx_ready_o
        && !rx_ready_o && count_o == 7'h00) else $error("flush failed");
    chk_flush_cause: assert property (flush_o |-> $past(fl))
        else $error("stray flush");
    chk_toggle_guard: assert property ($changed(toggle_o)
        |-> $past(tg_cause)) else $error("toggle changed");
    chk_toggle_lock: assert property (wr && is_c && !armed_r
        && !tg_evt |=> $stable(toggle_o))
        else $error("toggle written unarmed");
    chk_toggle_load: assert property (wr && is_c && host_mode_o
        && armed_r |=> toggle_o == $past(wr_dt))
        else $error("toggle not loaded");
    chk_count_up: assert property (evt_i.rx_byte && !evt_i.fifo_pop
        && !fl && count_o < DEPTH |=> count_o == $past(count_o) + 7'h01)
        else $error("count missed byte");
    chk_rx_set: assert property (evt_i.rx_pkt && !fl |=> rx_ready_o)
        else $error("rx ready not set");
    chk_tx_clear: assert property (evt_i.tx_done && !(wr && is_r)
        && !fl |=> !tx_ready_o) else $error("tx ready kept");
    chk_speed_hold: assert property ($changed(speed_o)
        |-> $past(sp_wr)) else $error("speed changed");
    chk_count_top: assert property (wb_ack_o && !wb_req_i.we && is_n
        |-> wb_dat_o[31:7] == 25'h0000000) else $error("count bit 7 set");
endmodule
bind uet_ep0_ctrl uet_ep0_ctrl_properties #(.DEPTH(DEPTH)) chk_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wb_req_i(wb_req_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .evt_i(evt_i),
    .host_mode_o(host_mode_o),
    .toggle_o(toggle_o), .speed_o(speed_o), .tx_ready_o(tx_ready_o),
    .rx_ready_o(rx_ready_o), .flush_o(flush_o), .count_o(count_o));

// [uet_engine_model.sv]
// packet engine stand-in: drives endpoint 0 event pulses
// assumes callers invoke its tasks from the clocked bench
`timescale 1ns/1ps
module uet_engine_model (
    input  wire logic           ref_clk_i, // clock
    output uet_pkg::uet_evt_type evt_o     // event pulses
);
    import uet_pkg::*;
    initial evt_o = '0;
    // one cycle of the given events, then idle
    task pulse(input logic [5:0] v);
        @(posedge ref_clk_i);
        evt_o <= v;
        @(posedge ref_clk_i);
        evt_o <= '0;
    endtask
    // n bytes land in the fifo, then the packet completes
    task rx_packet(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_i);
            evt_o <= 6'h08;
        end
        pulse(6'h10);
    endtask
endmodule

// [usb_ep0_toggle_flush_count_speed_test.sv]
// self-checking bench for uet_ep0_ctrl with the engine stand-in
// assumes the checker is bound through its own file
`timescale 1ns/1ps
module usb_ep0_toggle_flush_count_speed_test;
    import uet_pkg::*;
    logic           ref_clk_i = 1'h0;
    logic           resetn_i  = 1'h0;
    uet_wb_req_type wb_req    = '0;
    uet_evt_type    evt;
    logic [31:0]    wb_dat;
    logic [6:0]     count;
    logic [1:0]     speed;
    logic           wb_ack, host, tgl, tx_rdy, rx_rdy, flush, irq;
    int             n_mismatch = 0;
    int             check_count = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    uet_ep0_ctrl uet_ep0_ctrl_inst (.ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat),
        .wb_ack_o(wb_ack), .evt_i(evt), .host_mode_o(host),
        .toggle_o(tgl), .speed_o(speed), .tx_ready_o(tx_rdy),
        .rx_ready_o(rx_rdy), .flush_o(flush), .count_o(count),
        .irq_o(irq));
    uet_engine_model uet_engine_model_inst (.ref_clk_i(ref_clk_i),
        .evt_o(evt));
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task bus(input logic we, input logic [9:0] idx, input logic [7:0] d,
             output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        wb_req <= '{cyc:1'h1, stb:1'h1, we:we, sel:4'hF,
                    adr:{idx, 2'h0}, dat:{24'h000000, d}};
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wb_ack !== 1'h1 && n < 50);
        if (n >= 50) chk(32'h0000DEAD, 32'h00000000);
        q = wb_dat;
        wb_req <= '0;
    endtask
    task wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'h1, idx, d, q);
        #1;
    endtask
    task rd(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'h0, idx, 8'h00, q);
        chk(q, exp);
    endtask
    task tally_and_finish;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // reset values, unmapped address included
    task t_reset;
        logic [9:0] ix [8];
        ix = '{IDX_CTRL_HIGH, IDX_RX_COUNT, IDX_SPEED, IDX_MODE,
               IDX_READY, IDX_IRQ_STAT, IDX_IRQ_MASK, 10'h3FF};
        foreach (ix[i]) rd(ix[i], RST_WORD);
    endtask
    task t_speed;
        wr(IDX_SPEED, 8'hFF);
        chk(speed, SPEED_LOW);
        rd(IDX_SPEED, 32'h000000C0);
        wr(IDX_SPEED, 8'h80);
        chk(speed, SPEED_FULL);
    endtask
    task t_toggle;
        wr(IDX_CTRL_HIGH, 8'h04);
        wr(IDX_MODE, 8'h01);
        chk(host, 1'h1);
        wr(IDX_SPEED, 8'h80);
        wr(IDX_CTRL_HIGH, 8'h02);
        chk(tgl, 1'h0);
        wr(IDX_CTRL_HIGH, 8'h04);
        rd(IDX_CTRL_HIGH, 32'h00000004);
        wr(IDX_CTRL_HIGH, 8'h02);
        chk(tgl, 1'h1);
        rd(IDX_CTRL_HIGH, 32'h00000002);
        uet_engine_model_inst.pulse(6'h02);
        rd(IDX_CTRL_HIGH, 32'h00000000);
        uet_engine_model_inst.pulse(6'h03);
        rd(IDX_CTRL_HIGH, 32'h00000000);
    endtask
    task t_rx;
        wr(IDX_IRQ_MASK, 8'h03);
        uet_engine_model_inst.rx_packet(5);
        #1;
        chk({rx_rdy, irq}, 2'h3);
        rd(IDX_RX_COUNT, 32'h00000005);
        uet_engine_model_inst.pulse(6'h04);
        rd(IDX_RX_COUNT, 32'h00000004);
        rd(IDX_IRQ_STAT, 32'h00000002);
        rd(IDX_IRQ_STAT, 32'h00000000);
        wr(IDX_CTRL_HIGH, 8'h01);
        chk({rx_rdy, count}, 8'h00);
        chk(flush, 1'h1);
    endtask
    task t_tx;
        wr(IDX_READY, 8'h01);
        chk(tx_rdy, 1'h1);
        wr(IDX_IRQ_MASK, 8'h00);
        uet_engine_model_inst.pulse(6'h20);
        #1;
        chk({tx_rdy, irq}, 2'h0);
        rd(IDX_IRQ_STAT, 32'h00000001);
        uet_engine_model_inst.rx_packet(1);
        #1;
        chk(rx_rdy, 1'h1);
        wr(IDX_READY, 8'h02);
        chk(rx_rdy, 1'h0);
    endtask
    // watchdog cuts a hang short
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        repeat (10) @(posedge ref_clk_i);
        resetn_i <= 1'h1;
        t_reset;
        t_speed;
        t_toggle;
        t_rx;
        t_tx;
        tally_and_finish;
    end
endmodule
